// >>> rtl/radio_event_interrupt_mux.v
// Radio event collection, battery trip detection and two-line interrupt steering
`timescale 1ns/1ps
`default_nettype none
`include "event_irq_regs.vh"

module radio_event_interrupt_mux (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Register port from the control interface
    input wire [9:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wr_data,
    input wire reg_rd_en,
    output reg [7:0] reg_rd_data,
    output reg reg_rd_valid,
    // System event pulses
    input wire chip_available_pulse,
    input wire wakeup_timeout_pulse,
    input wire controller_ready_pulse,
    input wire power_on_reset_pulse,
    // Packet event pulses
    input wire channel_check_done_pulse,
    input wire sfd_detected_pulse,
    input wire sfd_sent_pulse,
    input wire frame_received_pulse,
    input wire tx_complete_pulse,
    // Battery monitor measurement in millivolts
    input wire [12:0] battery_supply_mv,
    // Interrupt request lines
    output wire irq_line_a,
    output wire irq_line_b,
    // Battery state
    output reg battery_low_reg
);

    // Control and status registers
    reg [7:0] line_a_system_event_mask_reg;
    reg [7:0] line_a_packet_event_mask_reg;
    reg [7:0] line_b_system_event_mask_reg;
    reg [7:0] line_b_packet_event_mask_reg;
    reg [7:0] system_event_flags_reg;
    reg [7:0] packet_event_flags_reg;
    reg [7:0] battery_trip_config_reg;

    reg [7:0] system_event_flags_next;
    reg [7:0] packet_event_flags_next;
    reg [7:0] reg_rd_data_next;

    // Event vectors and address hits
    wire [7:0] sys_events;
    wire [7:0] pkt_events;
    wire hit_line_a_sys;
    wire hit_line_a_pkt;
    wire hit_line_b_sys;
    wire hit_line_b_pkt;
    wire hit_sys_flags;
    wire hit_pkt_flags;
    wire hit_batt_cfg;

    // Battery comparator
    wire [4:0] trip_level_code;
    wire [12:0] trip_mv;
    wire battery_low_next;
    wire battery_alert_event;

    // Address decode
    assign hit_line_a_sys = (reg_addr == `ADDR_LINE_A_SYS_MASK);
    assign hit_line_a_pkt = (reg_addr == `ADDR_LINE_A_PKT_MASK);
    assign hit_line_b_sys = (reg_addr == `ADDR_LINE_B_SYS_MASK);
    assign hit_line_b_pkt = (reg_addr == `ADDR_LINE_B_PKT_MASK);
    assign hit_sys_flags = (reg_addr == `ADDR_SYS_FLAGS);
    assign hit_pkt_flags = (reg_addr == `ADDR_PKT_FLAGS);
    assign hit_batt_cfg = (reg_addr == `ADDR_BATT_TRIP_CFG);

    // Trip voltage from the configured code
    assign trip_level_code = battery_trip_config_reg[`TRIP_LEVEL_MSB:`TRIP_LEVEL_LSB];
    // Largest trip is 1700 + 62 * 31 = 3622 mV, fits in 13 bits
    assign trip_mv = `TRIP_BASE_MV + (`TRIP_STEP_MV * {8'h00, trip_level_code});
    // Compared every cycle, so a new trip code takes effect at once
    // and a code raised above a steady supply counts as a crossing
    assign battery_low_next = (battery_supply_mv < trip_mv);
    // Only the falling crossing raises an event, so a flat low supply
    // does not refill the flag right after software clears it
    assign battery_alert_event = battery_low_next & ~battery_low_reg;

    // System event vector; reserved positions never set
    assign sys_events[0] = 1'b0;
    assign sys_events[`SYS_BIT_CHIP_AVAILABLE] = chip_available_pulse;
    assign sys_events[`SYS_BIT_WAKEUP_TIMEOUT] = wakeup_timeout_pulse;
    assign sys_events[`SYS_BIT_CONTROLLER_READY] = controller_ready_pulse;
    assign sys_events[`SYS_BIT_POWER_ON_RESET] = power_on_reset_pulse;
    assign sys_events[`SYS_BIT_BATTERY_ALERT] = battery_alert_event;
    assign sys_events[7:6] = 2'b00;

    // Packet event vector
    assign pkt_events[`PKT_BIT_CHANNEL_CHECK_DONE] = channel_check_done_pulse;
    assign pkt_events[`PKT_BIT_SFD_DETECTED] = sfd_detected_pulse;
    assign pkt_events[`PKT_BIT_SFD_SENT] = sfd_sent_pulse;
    assign pkt_events[`PKT_BIT_FRAME_RECEIVED] = frame_received_pulse;
    assign pkt_events[`PKT_BIT_TX_COMPLETE] = tx_complete_pulse;
    assign pkt_events[7:5] = 3'b000;

    // Flags: writing a one clears; an event in the same cycle wins
    always @* begin
        system_event_flags_next = system_event_flags_reg;
        packet_event_flags_next = packet_event_flags_reg;
        if (reg_wr_en && hit_sys_flags) begin
            system_event_flags_next = system_event_flags_reg & ~reg_wr_data;
        end
        if (reg_wr_en && hit_pkt_flags) begin
            packet_event_flags_next = packet_event_flags_reg & ~reg_wr_data;
        end
        system_event_flags_next = (system_event_flags_next | sys_events) & `SYS_VALID_BITS;
        packet_event_flags_next = (packet_event_flags_next | pkt_events) & `PKT_VALID_BITS;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            system_event_flags_reg <= `RST_SYS_FLAGS;
            packet_event_flags_reg <= `RST_PKT_FLAGS;
            battery_low_reg <= 1'b0;
        end else begin
            system_event_flags_reg <= system_event_flags_next;
            packet_event_flags_reg <= packet_event_flags_next;
            battery_low_reg <= battery_low_next;
        end
    end

    // Mask and configuration writes; reserved bits are kept at zero
    always @(posedge ref_clk) begin
        if (rst) begin
            line_a_system_event_mask_reg <= `RST_SYS_MASK;
            line_a_packet_event_mask_reg <= `RST_PKT_MASK;
            line_b_system_event_mask_reg <= `RST_SYS_MASK;
            line_b_packet_event_mask_reg <= `RST_PKT_MASK;
            battery_trip_config_reg <= `RST_BATT_TRIP_CFG;
        end else if (reg_wr_en) begin
            if (hit_line_a_sys) begin
                line_a_system_event_mask_reg <= reg_wr_data & `SYS_VALID_BITS;
            end else if (hit_line_a_pkt) begin
                line_a_packet_event_mask_reg <= reg_wr_data & `PKT_VALID_BITS;
            end else if (hit_line_b_sys) begin
                line_b_system_event_mask_reg <= reg_wr_data & `SYS_VALID_BITS;
            end else if (hit_line_b_pkt) begin
                line_b_packet_event_mask_reg <= reg_wr_data & `PKT_VALID_BITS;
            end else if (hit_batt_cfg) begin
                battery_trip_config_reg <= {3'b000, reg_wr_data[`TRIP_LEVEL_MSB:`TRIP_LEVEL_LSB]};
            end
        end
    end

    // Read path; unmapped addresses read zero
    always @* begin
        if (hit_line_a_sys) begin
            reg_rd_data_next = line_a_system_event_mask_reg;
        end else if (hit_line_a_pkt) begin
            reg_rd_data_next = line_a_packet_event_mask_reg;
        end else if (hit_line_b_sys) begin
            reg_rd_data_next = line_b_system_event_mask_reg;
        end else if (hit_line_b_pkt) begin
            reg_rd_data_next = line_b_packet_event_mask_reg;
        end else if (hit_sys_flags) begin
            reg_rd_data_next = system_event_flags_reg;
        end else if (hit_pkt_flags) begin
            reg_rd_data_next = packet_event_flags_reg;
        end else if (hit_batt_cfg) begin
            reg_rd_data_next = battery_trip_config_reg;
        end else begin
            reg_rd_data_next = 8'h00;
        end
    end

    // Read data holds until the next read; valid is the read strobe delayed one cycle.
    // A read meeting a write in one cycle returns the old contents.
    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rd_data <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data <= reg_rd_data_next;
            end
        end
    end

    // Two request lines, each with its own pair of masks.
    // Lines are registered, so they trail a flag by one cycle.
    irq_line_gate #(
        .WIDTH(8)
    ) u_line_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .sys_flags(system_event_flags_reg),
        .sys_mask(line_a_system_event_mask_reg),
        .pkt_flags(packet_event_flags_reg),
        .pkt_mask(line_a_packet_event_mask_reg),
        .irq_reg(irq_line_a)
    );

    irq_line_gate #(
        .WIDTH(8)
    ) u_line_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .sys_flags(system_event_flags_reg),
        .sys_mask(line_b_system_event_mask_reg),
        .pkt_flags(packet_event_flags_reg),
        .pkt_mask(line_b_packet_event_mask_reg),
        .irq_reg(irq_line_b)
    );

endmodule // radio_event_interrupt_mux

`default_nettype wire

// >>> rtl/event_irq_regs.vh
// Register offsets, field positions and reset values of the radio event interrupt block
`ifndef EVENT_IRQ_REGS_VH
`define EVENT_IRQ_REGS_VH

`define ADDR_LINE_A_SYS_MASK 10'h3C7
`define ADDR_LINE_A_PKT_MASK 10'h3C8
`define ADDR_LINE_B_SYS_MASK 10'h3C9
`define ADDR_LINE_B_PKT_MASK 10'h3CA
`define ADDR_SYS_FLAGS 10'h3CB
`define ADDR_PKT_FLAGS 10'h3CC
`define ADDR_BATT_TRIP_CFG 10'h3E6

`define RST_SYS_MASK 8'h02
`define RST_PKT_MASK 8'h00
`define RST_SYS_FLAGS 8'h00
`define RST_PKT_FLAGS 8'h00
`define RST_BATT_TRIP_CFG 8'h00

`define SYS_VALID_BITS 8'h3E
`define PKT_VALID_BITS 8'h1F

`define SYS_BIT_CHIP_AVAILABLE 1
`define SYS_BIT_WAKEUP_TIMEOUT 2
`define SYS_BIT_CONTROLLER_READY 3
`define SYS_BIT_POWER_ON_RESET 4
`define SYS_BIT_BATTERY_ALERT 5

`define PKT_BIT_CHANNEL_CHECK_DONE 0
`define PKT_BIT_SFD_DETECTED 1
`define PKT_BIT_SFD_SENT 2
`define PKT_BIT_FRAME_RECEIVED 3
`define PKT_BIT_TX_COMPLETE 4

`define TRIP_LEVEL_MSB 4
`define TRIP_LEVEL_LSB 0
`define TRIP_BASE_MV 13'h06A4
`define TRIP_STEP_MV 13'h003E

`endif

// >>> rtl/irq_line_gate.v
// One interrupt request line: masks both flag registers and drives the line
`timescale 1ns/1ps
`default_nettype none

module irq_line_gate #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Flags and masks
    input wire [WIDTH-1:0] sys_flags,
    input wire [WIDTH-1:0] sys_mask,
    input wire [WIDTH-1:0] pkt_flags,
    input wire [WIDTH-1:0] pkt_mask,
    // Request line
    output reg irq_reg
);

    wire irq_next;

    assign irq_next = (|(sys_flags & sys_mask)) | (|(pkt_flags & pkt_mask));

    always @(posedge ref_clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

endmodule // irq_line_gate

`default_nettype wire

// >>> verification/event_irq_properties.sv
// Port-level checks on the radio event interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "event_irq_regs.vh"
module event_irq_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [9:0] reg_addr,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid,
    // Battery
    input wire logic [12:0] battery_supply_mv,
    input wire logic battery_low_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_no_valid; !reg_rd_en |=> !reg_rd_valid; endproperty
    a_no_valid: assert property (p_no_valid) else $error("spurious read valid");
    property p_sys_rsvd;
        reg_rd_en && (reg_addr == `ADDR_SYS_FLAGS || reg_addr == `ADDR_LINE_A_SYS_MASK
            || reg_addr == `ADDR_LINE_B_SYS_MASK) |=> (reg_rd_data & 8'hC1) == 8'h00;
    endproperty
    a_sys_rsvd: assert property (p_sys_rsvd) else $error("system reserved bit set");
    property p_pkt_rsvd;
        reg_rd_en && (reg_addr == `ADDR_PKT_FLAGS || reg_addr == `ADDR_LINE_A_PKT_MASK
            || reg_addr == `ADDR_LINE_B_PKT_MASK) |=> reg_rd_data[7:5] == 3'h0;
    endproperty
    a_pkt_rsvd: assert property (p_pkt_rsvd) else $error("packet reserved bit set");
    property p_cfg_rsvd;
        reg_rd_en && reg_addr == `ADDR_BATT_TRIP_CFG |=> reg_rd_data[7:5] == 3'h0;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("trip config reserved set");
    property p_unmapped; reg_rd_en && reg_addr == 10'h3FF |=> reg_rd_data == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Highest trip point is 3622 mV
    property p_batt_high; battery_supply_mv > 13'h0E26 |=> !battery_low_reg; endproperty
    a_batt_high: assert property (p_batt_high) else $error("low flag above trip");
    property p_batt_fall; $rose(battery_low_reg) |-> $past(battery_supply_mv) < 13'h0E26; endproperty
    a_batt_fall: assert property (p_batt_fall) else $error("low flag without drop");
endmodule // event_irq_properties
bind radio_event_interrupt_mux event_irq_properties chk (.ref_clk, .rst, .reg_addr, .reg_rd_en,
    .reg_rd_data, .reg_rd_valid, .battery_supply_mv, .battery_low_reg);
`default_nettype wire

// >>> verification/host_port_model.sv
// Host side of the register port
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [9:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    initial begin
        reg_addr = 10'h000;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    // Idle bus shows inverted data so stale values never match
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask
    task rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rd_valid ? reg_rd_data : 8'hXX;
    endtask
endmodule // host_port_model
`default_nettype wire

// >>> verification/radio_event_interrupt_mux_tb.sv
// Self-checking bench for the radio event interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module radio_event_interrupt_mux_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] ev = 9'h000;
    logic [12:0] batt_mv = 13'h1000;
    logic [7:0] d;
    wire logic [9:0] reg_addr;
    wire logic [7:0] reg_wr_data;
    wire logic [7:0] reg_rd_data;
    wire logic reg_wr_en;
    wire logic reg_rd_en;
    wire logic reg_rd_valid;
    wire logic irq_a;
    wire logic irq_b;
    wire logic batt_low;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Address, reset value, readback after writing all ones
    logic [25:0] rows [8] = '{{10'h3C7, 8'h02, 8'h3E}, {10'h3C8, 8'h00, 8'h1F},
        {10'h3C9, 8'h02, 8'h3E}, {10'h3CA, 8'h00, 8'h1F}, {10'h3CB, 8'h00, 8'h00},
        {10'h3CC, 8'h00, 8'h00}, {10'h3E6, 8'h00, 8'h1F}, {10'h3FF, 8'h00, 8'h00}};
    radio_event_interrupt_mux DUT (.ref_clk, .rst, .reg_addr, .reg_wr_en, .reg_wr_data,
        .reg_rd_en, .reg_rd_data, .reg_rd_valid, .chip_available_pulse(ev[0]),
        .wakeup_timeout_pulse(ev[1]), .controller_ready_pulse(ev[2]),
        .power_on_reset_pulse(ev[3]), .channel_check_done_pulse(ev[4]),
        .sfd_detected_pulse(ev[5]), .sfd_sent_pulse(ev[6]), .frame_received_pulse(ev[7]),
        .tx_complete_pulse(ev[8]), .battery_supply_mv(batt_mv), .irq_line_a(irq_a),
        .irq_line_b(irq_b), .battery_low_reg(batt_low));
    host_port_model host (.ref_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
        .reg_rd_data, .reg_rd_valid);
    always #4 ref_clk = ~ref_clk;
    task give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task fire(input int i);
        @(negedge ref_clk);
        ev = 9'h001 << i;
        @(negedge ref_clk);
        ev = 9'h000;
        @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            host.rd(rows[i][25:16], d);
            `CHK("reset value", rows[i][15:8], d)
            host.wr(rows[i][25:16], 8'hFF);
            host.rd(rows[i][25:16], d);
            `CHK("readback", rows[i][7:0], d)
        end
        for (int i = 0; i < 9; i++) begin
            fire(i);
            host.rd(i < 4 ? 10'h3CB : 10'h3CC, d);
            `CHK("flag", 8'h01 << (i < 4 ? i + 1 : i - 4), d)
            `CHK("line a", 1'b1, irq_a)
            `CHK("line b", 1'b1, irq_b)
            host.wr(i < 4 ? 10'h3CB : 10'h3CC, d);
            @(negedge ref_clk);
            `CHK("line a clear", 1'b0, irq_a)
            `CHK("line b clear", 1'b0, irq_b)
        end
        // Packet steering: only frame received on line A, no packet event on line B
        host.wr(10'h3C8, 8'h08);
        host.wr(10'h3CA, 8'h00);
        fire(6);
        `CHK("masked a", 1'b0, irq_a)
        fire(7);
        `CHK("frame a", 1'b1, irq_a)
        `CHK("frame b", 1'b0, irq_b)
        // Clear and a new frame event in one cycle: the event survives
        fork
            host.wr(10'h3CC, 8'h08);
            begin
                @(negedge ref_clk);
                ev = 9'h080;
                @(negedge ref_clk);
                ev = 9'h000;
            end
        join
        host.rd(10'h3CC, d);
        `CHK("set beats clear", 8'h0C, d)
        host.wr(10'h3CC, 8'hFF);
        // Trip is 3622 mV at code 31; equal is not below
        batt_mv = 13'h0E26;
        repeat (2) @(negedge ref_clk);
        host.rd(10'h3CB, d);
        `CHK("at trip", 8'h00, d)
        `CHK("not low at trip", 1'b0, batt_low)
        batt_mv = 13'h0E25;
        repeat (2) @(negedge ref_clk);
        host.rd(10'h3CB, d);
        `CHK("below trip", 8'h20, d)
        `CHK("low state", 1'b1, batt_low)
        `CHK("alert line", 1'b1, irq_a)
        host.wr(10'h3CB, 8'h20);
        host.rd(10'h3CB, d);
        `CHK("one per crossing", 8'h00, d)
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        `CHK("line after reset", 1'b0, irq_a)
        `CHK("low after reset", 1'b0, batt_low)
        host.rd(10'h3C9, d);
        `CHK("mask after reset", 8'h02, d)
        give_verdict();
    end
endmodule // radio_event_interrupt_mux_tb
`default_nettype wire
